// ---- common/secs_pkg.sv ----
// Package for the serial EEPROM command and status front end
package secs_pkg;

    // Core clock and link timing
    localparam int CLK_MHZ          = 50;
    localparam int WR_TIME_US       = 5000;
    localparam int WR_CYCLES        = WR_TIME_US * CLK_MHZ;

    // Op-code patterns with the don't-care bit 3 cleared
    localparam logic [7:0] OP_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_RD   = 8'h05;
    localparam logic [7:0] OP_STATUS_WR   = 8'h01;
    localparam logic [7:0] OP_ARRAY_RD    = 8'h03;
    localparam logic [7:0] OP_ARRAY_WR    = 8'h02;
    localparam logic [7:0] OP_ID_RD       = 8'h83;
    localparam logic [7:0] OP_ID_WR       = 8'h82;
    localparam logic [7:0] OP_X_MASK      = 8'hF7;

    // Status register field positions and the address select bit
    localparam int BIT_BUSY   = 0;
    localparam int BIT_LATCH  = 1;
    localparam int BIT_GLO    = 2;
    localparam int BIT_GHI    = 3;
    localparam int BIT_ARM    = 7;
    localparam int ADDR_SEL10 = 10;

    // Busy status pattern and guard reset code
    localparam logic [7:0] STATUS_ALL_ONES = 8'hFF;
    localparam logic [1:0] GUARD_RST       = 2'h0;

    // Protected region bounds
    localparam logic [15:0] REG_QUARTER = 16'h6000;
    localparam logic [15:0] REG_HALF    = 16'h4000;
    localparam logic [15:0] REG_ALL     = 16'h0000;
    localparam logic [15:0] REG_TOP     = 16'h7FFF;

    // Decoded instruction kinds
    typedef enum logic [8:0] {
        CMD_NONE   = 9'b0_0000_0001,
        CMD_LSET   = 9'b0_0000_0010,
        CMD_LCLR   = 9'b0_0000_0100,
        CMD_SRD    = 9'b0_0000_1000,
        CMD_SWR    = 9'b0_0001_0000,
        CMD_ARD    = 9'b0_0010_0000,
        CMD_AWR    = 9'b0_0100_0000,
        CMD_IDRD   = 9'b0_1000_0000,
        CMD_IDWR   = 9'b1_0000_0000
    } secs_cmd_e;

    // Frame phase
    typedef enum logic [3:0] {
        PH_OPCODE = 4'b0001,
        PH_ADDR   = 4'b0010,
        PH_DATA   = 4'b0100,
        PH_OUT    = 4'b1000
    } secs_phase_e;

    // Array access request leaving the front end
    typedef struct packed {
        logic        wr;
        logic        id_page;
        logic        lock_sel;
        logic [15:0] addr;
        logic [7:0]  data;
    } secs_req_s;

    // Non-volatile image of the protection bits
    typedef struct packed {
        logic       arm;
        logic [1:0] guard;
    } secs_nv_s;

endpackage : secs_pkg

// ---- hw/secs_fifo.sv ----
// Small valid/ready FIFO for array requests
`timescale 1ns/1ps
module secs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wp_ff;
    logic [AW-1:0]    rp_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    // Handshake terms
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rp_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointers and occupancy count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage writes
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end
endmodule : secs_fifo

// ---- hw/secs_front.sv ----
// SPI slave front end: framing, op-code decode and protection status
`timescale 1ns/1ps
module secs_front
    import secs_pkg::*;
#(
    parameter int WR_CYC = secs_pkg::WR_CYCLES,
    parameter int FDEPTH = 8
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    // SPI pins; inputs asynchronous to the core clock, outputs registered on it
    input  wire logic               spi_cs_n,
    input  wire logic               spi_sck,
    input  wire logic               spi_si,
    output logic                    spi_so,
    output logic                    spi_so_oe_n,
    input  wire logic               write_protect_n,
    input  wire logic               suspend_n,
    // Array request stream
    output logic                    req_valid,
    input  wire logic               req_ready,
    output secs_pkg::secs_req_s     req_data,
    // Array protection view
    output logic [15:0]             guard_base,
    output logic                    guard_any,
    output logic                    hw_guard,
    // Read data returned by the array side
    input  wire logic [7:0]         array_rdata
);
    import secs_pkg::*;

    localparam int WCW = $clog2(WR_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [2:0]  cs_s;
        logic [2:0]  sck_s;
        logic [1:0]  si_s;
        logic [1:0]  wp_s;
        logic [1:0]  hold_s;
        secs_phase_e phase;
        secs_cmd_e   cmd;
        logic [7:0]  shreg;
        logic [2:0]  bitcnt;
        logic        addr_hi;
        logic [15:0] addr;
        logic [7:0]  outreg;
        logic        so;
        logic        so_oe_n;
        logic        latch;
        secs_nv_s    nv;
        logic        swr_ok;
        logic [7:0]  swr_data;
        logic        byte_done;
        logic [WCW-1:0] wcnt;
        logic        req_v;
        secs_req_s   req;
        logic [15:0] gbase;
        logic        gany;
        logic        hwg;
    } secs_state_s;

    secs_state_s st_ff;
    secs_state_s nxt_st;
    logic [1:0]  rst_sync_ff;
    logic        rst_n_int;
    logic        head_take;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    secs_req_s   fifo_out_data;

    // Op-code decode, bit three masked
    function automatic secs_cmd_e decode_op(input logic [7:0] op);
        logic [7:0] m;
        m = op & OP_X_MASK;
        case (m)
            OP_LATCH_SET:   decode_op = CMD_LSET;
            OP_LATCH_CLEAR: decode_op = CMD_LCLR;
            OP_STATUS_RD:   decode_op = CMD_SRD;
            OP_STATUS_WR:   decode_op = CMD_SWR;
            OP_ARRAY_RD:    decode_op = CMD_ARD;
            OP_ARRAY_WR:    decode_op = CMD_AWR;
            OP_ID_RD:       decode_op = CMD_IDRD;
            OP_ID_WR:       decode_op = CMD_IDWR;
            default:        decode_op = CMD_NONE;
        endcase
    endfunction : decode_op

    // Guard code to lowest protected address
    function automatic logic [15:0] guard_floor(input logic [1:0] g);
        case (g)
            2'h1:    guard_floor = REG_QUARTER;
            2'h2:    guard_floor = REG_HALF;
            2'h3:    guard_floor = REG_ALL;
            default: guard_floor = REG_TOP;
        endcase
    endfunction : guard_floor

    ////////////////////////////////////////////////////////////////////////
    // Released reset copy
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic       cs_low;
        logic       sck_rise;
        logic       sck_fall;
        logic       held;
        logic       busy;
        logic       bit_in;
        logic [7:0] byte_in;
        logic [7:0] status;
        logic       deselect;

        nxt_st = st_ff;
        // Two-stage synchronisers, third stage for edges
        nxt_st.cs_s   = {st_ff.cs_s[1:0], spi_cs_n};
        nxt_st.sck_s  = {st_ff.sck_s[1:0], spi_sck};
        nxt_st.si_s   = {st_ff.si_s[0], spi_si};
        nxt_st.wp_s   = {st_ff.wp_s[0], write_protect_n};
        nxt_st.hold_s = {st_ff.hold_s[0], suspend_n};

        cs_low   = !st_ff.cs_s[1];
        deselect = st_ff.cs_s[1] && !st_ff.cs_s[2];
        sck_rise = st_ff.sck_s[1] && !st_ff.sck_s[2];
        sck_fall = !st_ff.sck_s[1] && st_ff.sck_s[2];
        // suspend sampled as a clean level
        held     = !st_ff.hold_s[1];
        busy     = (st_ff.wcnt != '0);
        bit_in   = st_ff.si_s[1];
        byte_in  = {st_ff.shreg[6:0], bit_in};

        nxt_st.hwg = !st_ff.wp_s[1] && st_ff.nv.arm;
        nxt_st.gbase = guard_floor(st_ff.nv.guard);
        nxt_st.gany  = (st_ff.nv.guard != GUARD_RST);

        if (busy) begin
            status = STATUS_ALL_ONES;
        end else begin
            // bits four to six read zero
            status = 8'h00;
            status[BIT_BUSY]  = 1'b0;
            status[BIT_LATCH] = st_ff.latch;
            status[BIT_GLO]   = st_ff.nv.guard[0];
            status[BIT_GHI]   = st_ff.nv.guard[1];
            status[BIT_ARM]   = st_ff.nv.arm;
        end

        if (busy) begin
            nxt_st.wcnt = st_ff.wcnt - 1'b1;
        end

        // Request handed to FIFO
        if (st_ff.req_v && fifo_in_ready) begin
            nxt_st.req_v = 1'b0;
        end

        if (!cs_low) begin
            nxt_st.so_oe_n = 1'b1;
            nxt_st.phase   = PH_OPCODE;
            nxt_st.bitcnt  = 3'h0;
            nxt_st.addr_hi = 1'b0;
            if (deselect && st_ff.byte_done && !busy) begin
                case (st_ff.cmd)
                    CMD_LSET: nxt_st.latch = 1'b1;
                    CMD_LCLR: nxt_st.latch = 1'b0;
                    CMD_SWR: begin
                        if (st_ff.swr_ok) begin
                            nxt_st.nv.guard = st_ff.swr_data[BIT_GHI:BIT_GLO];
                            // arm cannot drop under low pin
                            if (st_ff.wp_s[1] || st_ff.swr_data[BIT_ARM]) begin
                                nxt_st.nv.arm = st_ff.swr_data[BIT_ARM];
                            end
                            nxt_st.wcnt  = WCW'(WR_CYC);
                            nxt_st.latch = 1'b0;
                        end
                    end
                    CMD_AWR: begin
                        if (st_ff.latch) begin
                            nxt_st.wcnt  = WCW'(WR_CYC);
                            nxt_st.latch = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
            if (deselect) begin
                nxt_st.cmd       = CMD_NONE;
                nxt_st.byte_done = 1'b0;
                nxt_st.swr_ok    = 1'b0;
            end
        end else if (held) begin
            nxt_st.so_oe_n = 1'b1;
        end else begin
            if (st_ff.phase == PH_OUT) begin
                nxt_st.so_oe_n = 1'b0;
            end
            if (sck_rise) begin
                nxt_st.shreg     = byte_in;
                nxt_st.bitcnt    = st_ff.bitcnt + 3'h1;
                nxt_st.byte_done = (st_ff.bitcnt == 3'h7);
                if (st_ff.bitcnt == 3'h7) begin
                    case (st_ff.phase)
                        PH_OPCODE: begin
                            nxt_st.cmd = decode_op(byte_in);
                            // busy ignores all but status read
                            if (busy && decode_op(byte_in) != CMD_SRD) begin
                                nxt_st.cmd = CMD_NONE;
                            end
                            if (decode_op(byte_in) == CMD_SRD) begin
                                nxt_st.phase  = PH_OUT;
                                nxt_st.outreg = status;
                            end else if (decode_op(byte_in) == CMD_SWR) begin
                                nxt_st.phase = PH_DATA;
                            end else if (decode_op(byte_in) inside
                                         {CMD_ARD, CMD_AWR, CMD_IDRD, CMD_IDWR}) begin
                                nxt_st.phase = PH_ADDR;
                            end
                        end
                        PH_ADDR: begin
                            nxt_st.addr_hi = 1'b1;
                            if (st_ff.addr_hi) begin
                                nxt_st.addr = {st_ff.addr[15:8], byte_in};
                                if (st_ff.cmd inside {CMD_ARD, CMD_IDRD}) begin
                                    nxt_st.phase  = PH_OUT;
                                    nxt_st.outreg = array_rdata;
                                end else begin
                                    nxt_st.phase = PH_DATA;
                                end
                                // Fetch request only for the read kinds
                                if (st_ff.cmd inside {CMD_ARD, CMD_IDRD} && !nxt_st.req_v) begin
                                    nxt_st.req_v        = 1'b1;
                                    nxt_st.req.wr       = 1'b0;
                                    nxt_st.req.id_page  = st_ff.cmd inside
                                                          {CMD_IDRD, CMD_IDWR};
                                    nxt_st.req.lock_sel = st_ff.addr[ADDR_SEL10];
                                    nxt_st.req.addr     = {st_ff.addr[15:8], byte_in};
                                    nxt_st.req.data     = 8'h00;
                                end
                            end else begin
                                nxt_st.addr = {byte_in, st_ff.addr[7:0]};
                            end
                        end
                        PH_DATA: begin
                            if (st_ff.cmd == CMD_SWR) begin
                                nxt_st.swr_data = byte_in;
                                // writable only with latch and no guard
                                nxt_st.swr_ok   = st_ff.latch && !st_ff.hwg;
                            end else if (st_ff.cmd != CMD_NONE && !nxt_st.req_v) begin
                                nxt_st.req_v        = 1'b1;
                                nxt_st.req.wr       = st_ff.latch;
                                nxt_st.req.id_page  = (st_ff.cmd == CMD_IDWR);
                                nxt_st.req.lock_sel = st_ff.addr[ADDR_SEL10];
                                nxt_st.req.addr     = st_ff.addr;
                                nxt_st.req.data     = byte_in;
                                nxt_st.addr         = st_ff.addr + 16'h0001;
                            end
                        end
                        PH_OUT: begin
                            // Reload the next output byte
                            nxt_st.outreg = (st_ff.cmd == CMD_SRD) ? status : array_rdata;
                        end
                        default: nxt_st.phase = PH_OPCODE;
                    endcase
                end
            end
            if (sck_fall && st_ff.phase == PH_OUT) begin
                nxt_st.so      = st_ff.outreg[3'h7 - st_ff.bitcnt];
                nxt_st.so_oe_n = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_ff.cs_s      <= 3'h7;
            st_ff.sck_s     <= 3'h0;
            st_ff.si_s      <= 2'h0;
            st_ff.wp_s      <= 2'h3;
            st_ff.hold_s    <= 2'h3;
            st_ff.phase     <= PH_OPCODE;
            st_ff.cmd       <= CMD_NONE;
            st_ff.shreg     <= 8'h00;
            st_ff.bitcnt    <= 3'h0;
            st_ff.addr_hi   <= 1'b0;
            st_ff.addr      <= 16'h0000;
            st_ff.outreg    <= 8'h00;
            st_ff.so        <= 1'b0;
            st_ff.so_oe_n   <= 1'b1;
            st_ff.latch     <= 1'b0;
            st_ff.nv        <= '0;
            st_ff.swr_ok    <= 1'b0;
            st_ff.swr_data  <= 8'h00;
            st_ff.byte_done <= 1'b0;
            st_ff.wcnt      <= '0;
            st_ff.req_v     <= 1'b0;
            st_ff.req       <= '0;
            st_ff.gbase     <= REG_TOP;
            st_ff.gany      <= 1'b0;
            st_ff.hwg       <= 1'b0;
        end else begin
            st_ff.cs_s      <= nxt_st.cs_s;
            st_ff.sck_s     <= nxt_st.sck_s;
            st_ff.si_s      <= nxt_st.si_s;
            st_ff.wp_s      <= nxt_st.wp_s;
            st_ff.hold_s    <= nxt_st.hold_s;
            st_ff.phase     <= nxt_st.phase;
            st_ff.cmd       <= nxt_st.cmd;
            st_ff.shreg     <= nxt_st.shreg;
            st_ff.bitcnt    <= nxt_st.bitcnt;
            st_ff.addr_hi   <= nxt_st.addr_hi;
            st_ff.addr      <= nxt_st.addr;
            st_ff.outreg    <= nxt_st.outreg;
            st_ff.so        <= nxt_st.so;
            st_ff.so_oe_n   <= nxt_st.so_oe_n;
            st_ff.latch     <= nxt_st.latch;
            st_ff.nv        <= nxt_st.nv;
            st_ff.swr_ok    <= nxt_st.swr_ok;
            st_ff.swr_data  <= nxt_st.swr_data;
            st_ff.byte_done <= nxt_st.byte_done;
            st_ff.wcnt      <= nxt_st.wcnt;
            st_ff.req_v     <= nxt_st.req_v;
            st_ff.req       <= nxt_st.req;
            st_ff.gbase     <= nxt_st.gbase;
            st_ff.gany      <= nxt_st.gany;
            st_ff.hwg       <= nxt_st.hwg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request FIFO toward the array engine
    secs_fifo #(
        .WIDTH ($bits(secs_req_s)),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst_n     (rst_n_int),
        .in_valid  (st_ff.req_v),
        .in_ready  (fifo_in_ready),
        .in_data   (st_ff.req),
        .out_valid (fifo_out_valid),
        .out_ready (head_take),
        .out_data  (fifo_out_data)
    );

    // Output register for the stream head
    logic      req_valid_ff;
    secs_req_s req_data_ff;
    // Head is free or being taken: pull the next entry
    assign head_take = !req_valid_ff || req_ready;
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            req_valid_ff <= 1'b0;
            req_data_ff  <= '0;
        end else if (head_take) begin
            req_valid_ff <= fifo_out_valid;
            req_data_ff  <= fifo_out_data;
        end
    end

    // Outputs
    assign spi_so      = st_ff.so;
    assign spi_so_oe_n = st_ff.so_oe_n;
    assign req_valid   = req_valid_ff;
    assign req_data    = req_data_ff;
    assign guard_base  = st_ff.gbase;
    assign guard_any   = st_ff.gany;
    assign hw_guard    = st_ff.hwg;
endmodule : secs_front

// ---- tb/secs_front_asserts.sv ----
// Checker for the serial front end ports
`timescale 1ns/1ps
module secs_front_asserts
    import secs_pkg::*;
(
    // Clock, reset and pins
    input wire logic core_clk, reset_n, spi_cs_n, suspend_n, write_protect_n, spi_so_oe_n,
    // Request stream and guard view
    input wire logic req_valid, req_ready, guard_any, hw_guard,
    input wire logic [15:0] guard_base,
    input wire secs_pkg::secs_req_s req_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    idle_so_float_a: assert property (spi_cs_n [*8] |-> spi_so_oe_n)
        else $error("so driven idle");
    held_so_float_a: assert property (!suspend_n [*8] |-> spi_so_oe_n)
        else $error("so driven held");
    pin_high_free_a: assert property (write_protect_n [*6] |-> !hw_guard)
        else $error("guard with pin high");
    base_none_a: assert property (!guard_any |-> guard_base == 16'h7FFF)
        else $error("base without guard");
    base_legal_a: assert property (guard_any |-> guard_base inside
        {16'h6000, 16'h4000, 16'h0000})
        else $error("base illegal");
    guard_frozen_a: assert property (hw_guard ##1 hw_guard |-> $stable(guard_base))
        else $error("guard moved");
    req_valid_hold_a: assert property (req_valid && !req_ready |=> req_valid)
        else $error("valid dropped");
    req_data_hold_a: assert property (req_valid && !req_ready |=> $stable(req_data))
        else $error("data moved");
    cover property ($rose(guard_any));
    cover property ($rose(hw_guard));
    cover property (req_valid && req_ready);
    cover property (!suspend_n && !spi_cs_n);
endmodule : secs_front_asserts
bind secs_front secs_front_asserts u_chk (.core_clk(core_clk), .reset_n(reset_n),
    .spi_cs_n(spi_cs_n), .suspend_n(suspend_n), .write_protect_n(write_protect_n),
    .spi_so_oe_n(spi_so_oe_n), .req_valid(req_valid), .req_ready(req_ready),
    .guard_any(guard_any), .hw_guard(hw_guard), .guard_base(guard_base),
    .req_data(req_data));

// ---- tb/secs_spi_master.sv ----
// SPI master model: select, clock and data
`timescale 1ns/1ps
module secs_spi_master (
    // Clock and serial pins
    input  wire logic core_clk,
    input  wire logic so_w,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    initial begin
        hold_n = 1'b1;
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Half of the 160 ns link clock
    task automatic half;
        repeat (4) @(negedge core_clk);
    endtask : half
    // Whole bytes out, last byte in; optional suspend before bit pause
    task automatic xfer(input logic [7:0] tx [4], input int n, input int pause,
                        output logic [7:0] rx);
        int k;
        k = 0;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) for (int b = 7; b >= 0; b--) begin
            si = tx[i][b];
            if (k == pause) begin
                // Suspend moves only while clock is low
                hold_n = 1'b0;
                half();
                repeat (2) begin
                    sck = 1'b1;
                    half();
                    sck = 1'b0;
                    half();
                end
                hold_n = 1'b1;
            end
            k++;
            half();
            sck = 1'b1;
            half();
            rx = {rx[6:0], so_w};
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        si = ~si;
        half();
        half();
    endtask : xfer
endmodule : secs_spi_master

// ---- tb/tb_top.sv ----
// Testbench for the serial front end
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
    import secs_pkg::*;
    logic core_clk = 1'b0, reset_n = 1'b0, write_protect_n = 1'b1;
    logic suspend_n, req_ready = 1'b0;
    logic spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe_n, so_w;
    logic req_valid, guard_any, hw_guard;
    logic [15:0] guard_base;
    secs_req_s req_data;
    logic [7:0] st;
    int errors = 0, checks = 0;
    // Released output pulled up
    assign so_w = spi_so_oe_n ? 1'b1 : spi_so;
    initial forever #10 core_clk = ~core_clk;
    secs_front #(.WR_CYC(400)) dut (.core_clk(core_clk), .reset_n(reset_n),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so),
        .spi_so_oe_n(spi_so_oe_n), .write_protect_n(write_protect_n),
        .suspend_n(suspend_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_data(req_data), .guard_base(guard_base), .guard_any(guard_any),
        .hw_guard(hw_guard), .array_rdata(8'h00));
    secs_spi_master master (.core_clk(core_clk), .so_w(so_w), .cs_n(spi_cs_n),
        .sck(spi_sck), .si(spi_si), .hold_n(suspend_n));
    task automatic print_verdict;
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_n
    task automatic cmd(input logic [7:0] op);
        master.xfer('{op, 8'h00, 8'h00, 8'h00}, 1, -1, st);
    endtask : cmd
    task automatic rd;
        master.xfer('{OP_STATUS_RD, 8'h00, 8'h00, 8'h00}, 2, -1, st);
    endtask : rd
    // Latch set ahead of status write
    task automatic wrs(input logic [7:0] d);
        cmd(OP_LATCH_SET);
        master.xfer('{OP_STATUS_WR, d, 8'h00, 8'h00}, 2, -1, st);
    endtask : wrs
    // Main sequence
    initial begin
        wait_n(16);
        reset_n = 1'b1;
        wait_n(8);
        rd();
        `CHK("status", 8'h00, st)
        master.xfer('{OP_STATUS_WR, 8'h8C, 8'h00, 8'h00}, 2, -1, st);
        rd();
        `CHK("status", 8'h00, st)
        cmd(OP_LATCH_SET | 8'h08);
        rd();
        `CHK("status", 8'h02, st)
        cmd(OP_LATCH_CLEAR);
        rd();
        `CHK("status", 8'h00, st)
        wrs(8'hFC);
        rd();
        `CHK("status", 8'hFF, st)
        wait_n(450);
        rd();
        `CHK("status", 8'h8C, st)
        `CHK("base", 16'h0000, guard_base)
        write_protect_n = 1'b0;
        wait_n(8);
        `CHK("hw guard", 1'b1, hw_guard)
        wrs(8'h00);
        wait_n(450);
        rd();
        `CHK("status", 8'h8C, st & 8'h8C)
        cmd(OP_LATCH_SET);
        master.xfer('{OP_ARRAY_WR, 8'h12, 8'h34, 8'hA5}, 4, -1, st);
        for (int i = 0; i < 200 && req_valid !== 1'b1; i++) wait_n(1);
        `CHK("req valid", 1'b1, req_valid)
        if (req_valid !== 1'b1) print_verdict();
        `CHK("req addr", 16'h1234, req_data.addr)
        `CHK("req data", 8'hA5, req_data.data)
        `CHK("req wr", 1'b1, req_data.wr)
        req_ready = 1'b1;
        wait_n(450);
        write_protect_n = 1'b1;
        wait_n(8);
        wrs(8'h04);
        cmd(OP_LATCH_SET);
        wait_n(450);
        rd();
        `CHK("status", 8'h04, st)
        `CHK("base", 16'h6000, guard_base)
        // Status read suspended mid-byte, clock toggled while held
        master.xfer('{OP_STATUS_RD, 8'h00, 8'h00, 8'h00}, 2, 11, st);
        `CHK("held status", 8'h04, st)
        print_verdict();
    end
endmodule : tb_top
